/* File: logic/ars_pkg.sv */
// Shared constants and types of the sector read command block.
// Assumes a 32-bit Wishbone register bus and a medium engine outside.
package ars_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [8:0] IDX_ERROR   = 9'h1F1;
  localparam logic [8:0] IDX_FEATURE = 9'h1F1;
  localparam logic [8:0] IDX_COUNT   = 9'h1F2;
  localparam logic [8:0] IDX_SECTOR  = 9'h1F3;
  localparam logic [8:0] IDX_CYL_LO  = 9'h1F4;
  localparam logic [8:0] IDX_CYL_HI  = 9'h1F5;
  localparam logic [8:0] IDX_DRVHEAD = 9'h1F6;
  localparam logic [8:0] IDX_STATE   = 9'h1F7;
  localparam logic [8:0] IDX_COMMAND = 9'h1F7;
  // Drive/head field positions.
  localparam int DH_LBA_BIT = 6;
  localparam int DH_DRV_BIT = 4;
  localparam int DH_HEAD_HI = 3;
  // Status bit positions.
  localparam int ST_BUSY  = 7;
  localparam int ST_READY = 6;
  localparam int ST_SEEKD = 4;
  localparam int ST_XREQ  = 3;
  localparam int ST_ERR   = 0;
  // Error register values.
  localparam logic [7:0] ER_NONE    = 8'h00;
  localparam logic [7:0] ER_UNCORR  = 8'h40;
  localparam logic [7:0] ER_ABORTED = 8'h04;
  localparam logic [7:0] ER_DIAG_OK = 8'h01;
  // Command codes.
  localparam logic [7:0] CMD_READ_SECT = 8'h20;
  localparam logic [7:0] CMD_DIAG      = 8'h90;
  // Count and geometry.
  localparam logic [8:0] CNT_FULL      = 9'h100;
  localparam logic [7:0] GEO_SECT_TRK  = 8'h3F;
  localparam logic [3:0] GEO_LAST_HEAD = 4'hF;
  localparam logic [7:0] FIRST_SECT    = 8'h01;
  // Reset values of the task file.
  localparam logic [7:0] RST_TASK   = 8'h00;
  localparam logic [7:0] RST_COUNT  = 8'h01;
  localparam logic [7:0] RST_SECTOR = 8'h01;
  localparam logic [7:0] RST_DRVHD  = 8'hA0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEEK,
    ST_READ,
    ST_XFER
  } ars_state_type;

  // Address held in the task file, most significant first.
  typedef struct packed {
    logic [7:0] drv_head;
    logic [7:0] cyl_hi;
    logic [7:0] cyl_lo;
    logic [7:0] sector;
  } ars_addr_type;
endpackage : ars_pkg

/* File: logic/ars_read_cmd.sv */
// Task file registers and sector read command engine of the drive.
// Assumes a classic Wishbone master and a medium engine that answers
// each seek and sector read request with a one-cycle pulse.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ns
module ars_read_cmd (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [10:0]           adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  input  wire logic                  dev_is_slave_i,
  output logic                       seek_req_o,
  input  wire logic                  seek_done_i,
  output logic                       rd_req_o,
  input  wire logic                  rd_ok_i,
  input  wire logic                  rd_fail_i,
  output ars_pkg::ars_addr_type      media_addr_o,
  output logic                       media_lba_mode_o,
  output logic [27:0]                media_lba_o,
  output logic                       xfer_req_o,
  input  wire logic                  xfer_done_i
);
  ars_pkg::ars_state_type st_q, st_d;
  ars_pkg::ars_addr_type  ta_q, ta_d, nxt;
  logic [7:0]  cnt_reg_q, cnt_reg_d, feat_q, feat_d, er_q, er_d;
  logic [8:0]  left_q, left_d;
  logic [19:0] trk_q, trk_d;
  logic        busy_q, busy_d, drq_q, drq_d, err_q, err_d;
  logic        ack_q, ack_d, seek_q, seek_d, rdrq_q, rdrq_d;
  logic [31:0] rdat_q, rdat_d;
  logic        wr_en, rd_take, idle_host, is_read, dv_ok, lba;
  logic [8:0]  idx;
  logic [7:0]  wb, status;

  // Track tag of an address; a tag that differs from the last sought track makes the command seek first.
  function automatic logic [19:0] trk_of(ars_pkg::ars_addr_type a);
    if (a.drv_head[ars_pkg::DH_LBA_BIT]) begin
      trk_of = {a.drv_head[3:0], a.cyl_hi, a.cyl_lo};
    end else begin
      trk_of = {a.cyl_hi, a.cyl_lo, a.drv_head[3:0]};
    end
  endfunction : trk_of

  // Next sector address in either mode.
  function automatic ars_pkg::ars_addr_type adv(ars_pkg::ars_addr_type a);
    logic [27:0] l;
    logic [15:0] c;
    adv = a;
    l = {a.drv_head[3:0], a.cyl_hi, a.cyl_lo, a.sector} + 28'h0000001;
    c = {a.cyl_hi, a.cyl_lo} + 16'h0001;
    if (a.drv_head[ars_pkg::DH_LBA_BIT]) begin
      adv.drv_head[3:0] = l[27:24];
      adv.cyl_hi = l[23:16];
      adv.cyl_lo = l[15:8];
      adv.sector = l[7:0];
    end else if (a.sector < ars_pkg::GEO_SECT_TRK) begin
      adv.sector = a.sector + 8'h01;
    end else begin
      adv.sector = ars_pkg::FIRST_SECT;
      if (a.drv_head[3:0] == ars_pkg::GEO_LAST_HEAD) begin
        adv.drv_head[3:0] = 4'h0;
        adv.cyl_hi = c[15:8];
        adv.cyl_lo = c[7:0];
      end else begin
        adv.drv_head[3:0] = a.drv_head[3:0] + 4'h1;
      end
    end
  endfunction : adv

  assign idx       = adr_i[10:2];
  assign wb        = dat_i[7:0];
  assign wr_en     = cyc_i && stb_i && we_i && ack_q && sel_i[0];
  assign rd_take   = cyc_i && stb_i && !ack_q;
  assign idle_host = !busy_q && !drq_q;
  assign lba       = ta_q.drv_head[ars_pkg::DH_LBA_BIT];
  // Bit 0 of the code is an option bit and takes no part in decode.
  assign is_read   = wb[7:1] == ars_pkg::CMD_READ_SECT[7:1];
  // Only the drive bit selects; the head field plays no part here.
  assign dv_ok     = ta_q.drv_head[ars_pkg::DH_DRV_BIT] == dev_is_slave_i;

  always_comb begin
    status = 8'h00;
    status[ars_pkg::ST_BUSY]  = busy_q;
    status[ars_pkg::ST_READY] = !busy_q;
    status[ars_pkg::ST_SEEKD] = st_q != ars_pkg::ST_SEEK;
    status[ars_pkg::ST_XREQ]  = drq_q;
    status[ars_pkg::ST_ERR]   = err_q;
  end

  always_comb begin
    st_d = st_q;
    ta_d = ta_q;
    cnt_reg_d = cnt_reg_q;
    feat_d = feat_q;
    er_d = er_q;
    left_d = left_q;
    trk_d = trk_q;
    busy_d = busy_q;
    drq_d = drq_q;
    err_d = err_q;
    seek_d = 1'b0;
    rdrq_d = 1'b0;
    nxt = adv(ta_q);
    ack_d = rd_take;
    rdat_d = rdat_q;
    if (rd_take) begin
      unique case (idx)
        ars_pkg::IDX_ERROR:   rdat_d = {24'h000000, er_q};
        ars_pkg::IDX_COUNT:   rdat_d = {24'h000000, cnt_reg_q};
        ars_pkg::IDX_SECTOR:  rdat_d = {24'h000000, ta_q.sector};
        ars_pkg::IDX_CYL_LO:  rdat_d = {24'h000000, ta_q.cyl_lo};
        ars_pkg::IDX_CYL_HI:  rdat_d = {24'h000000, ta_q.cyl_hi};
        ars_pkg::IDX_DRVHEAD: rdat_d = {24'h000000, ta_q.drv_head};
        ars_pkg::IDX_STATE:   rdat_d = {24'h000000, status};
        default:              rdat_d = 32'h00000000;
      endcase
    end
    // Parameters are only taken while the host may legally write them.
    if (wr_en && idle_host) begin
      unique case (idx)
        // Stored only; a read of this index returns the error register and no command logic reads it.
        ars_pkg::IDX_FEATURE: feat_d = wb;
        ars_pkg::IDX_COUNT:   cnt_reg_d = wb;
        ars_pkg::IDX_SECTOR:  ta_d.sector = wb;
        ars_pkg::IDX_CYL_LO:  ta_d.cyl_lo = wb;
        ars_pkg::IDX_CYL_HI:  ta_d.cyl_hi = wb;
        ars_pkg::IDX_DRVHEAD: ta_d.drv_head = wb;
        ars_pkg::IDX_COMMAND: begin
          if (wb == ars_pkg::CMD_DIAG) begin
            // Both drives run this one regardless of the drive bit.
            er_d = ars_pkg::ER_DIAG_OK;
            err_d = 1'b0;
          end else if (!dv_ok) begin
            er_d = er_q;
          end else if (is_read) begin
            // Start at once from the task file as it stands.
            busy_d = 1'b1;
            err_d = 1'b0;
            er_d = ars_pkg::ER_NONE;
            left_d = (cnt_reg_q == 8'h00) ? ars_pkg::CNT_FULL
                                          : {1'b0, cnt_reg_q};
            if (trk_of(ta_q) != trk_q) begin
              st_d = ars_pkg::ST_SEEK;
              seek_d = 1'b1;
            end else begin
              st_d = ars_pkg::ST_READ;
              rdrq_d = 1'b1;
            end
          end else begin
            err_d = 1'b1;
            er_d = ars_pkg::ER_ABORTED;
          end
        end
        default: feat_d = feat_q;
      endcase
    end
    unique case (st_q)
      ars_pkg::ST_IDLE: busy_d = busy_d;
      ars_pkg::ST_SEEK: begin
        if (seek_done_i) begin
          trk_d = trk_of(ta_q);
          st_d = ars_pkg::ST_READ;
          rdrq_d = 1'b1;
        end
      end
      ars_pkg::ST_READ: begin
        if (rd_ok_i || rd_fail_i) begin
          // Request goes up for good and bad sectors alike.
          drq_d = 1'b1;
          busy_d = 1'b0;
          st_d = ars_pkg::ST_XFER;
          if (rd_fail_i) begin
            err_d = 1'b1;
            er_d = ars_pkg::ER_UNCORR;
          end
        end
      end
      ars_pkg::ST_XFER: begin
        if (xfer_done_i) begin
          drq_d = 1'b0;
          if (err_q) begin
            // Address stays on the failing sector; it counts as untaken.
            cnt_reg_d = left_q[7:0];
            st_d = ars_pkg::ST_IDLE;
          end else if (left_q == 9'h001) begin
            // Task file already holds the last sector read.
            cnt_reg_d = 8'h00;
            left_d = 9'h000;
            st_d = ars_pkg::ST_IDLE;
          end else begin
            left_d = left_q - 9'h001;
            cnt_reg_d = 8'(left_q - 9'h001);
            ta_d = nxt;
            busy_d = 1'b1;
            if (trk_of(nxt) != trk_q) begin
              st_d = ars_pkg::ST_SEEK;
              seek_d = 1'b1;
            end else begin
              st_d = ars_pkg::ST_READ;
              rdrq_d = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ars_pkg::ST_IDLE;
      ta_q <= '{ars_pkg::RST_DRVHD, ars_pkg::RST_TASK,
                ars_pkg::RST_TASK, ars_pkg::RST_SECTOR};
      cnt_reg_q <= ars_pkg::RST_COUNT;
      feat_q <= ars_pkg::RST_TASK;
      er_q <= ars_pkg::ER_DIAG_OK;
      left_q <= 9'h000;
      trk_q <= 20'h00000;
      busy_q <= 1'b0;
      drq_q <= 1'b0;
      err_q <= 1'b0;
      ack_q <= 1'b0;
      seek_q <= 1'b0;
      rdrq_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      st_q <= st_d;
      ta_q <= ta_d;
      cnt_reg_q <= cnt_reg_d;
      feat_q <= feat_d;
      er_q <= er_d;
      left_q <= left_d;
      trk_q <= trk_d;
      busy_q <= busy_d;
      drq_q <= drq_d;
      err_q <= err_d;
      ack_q <= ack_d;
      seek_q <= seek_d;
      rdrq_q <= rdrq_d;
      rdat_q <= rdat_d;
    end
  end

  assign dat_o            = rdat_q;
  assign ack_o            = ack_q;
  assign seek_req_o       = seek_q;
  assign rd_req_o         = rdrq_q;
  assign xfer_req_o       = drq_q;
  assign media_addr_o     = ta_q;
  assign media_lba_mode_o = lba;
  assign media_lba_o      = {ta_q.drv_head[3:0], ta_q.cyl_hi,
                             ta_q.cyl_lo, ta_q.sector};

  logic       cmd_wr;
  logic [7:0] left_lo;
  assign cmd_wr  = wr_en && idle_host && idx == ars_pkg::IDX_COMMAND;
  // Low byte of the remaining count; 256 left reads back as 00.
  assign left_lo = left_q[7:0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_read_start;
    cmd_wr && is_read && wb != ars_pkg::CMD_DIAG && dv_ok;
  endsequence
  sequence s_sector_bad;
    st_q == ars_pkg::ST_READ && rd_fail_i;
  endsequence
  sequence s_err_taken;
    st_q == ars_pkg::ST_XFER && xfer_done_i && err_q;
  endsequence

  chk_cmd_decode: assert property (
    s_read_start |=> busy_q && st_q != ars_pkg::ST_IDLE)
    else $error("Read code did not start the command.");
  chk_count_full: assert property (
    s_read_start and cnt_reg_q == 8'h00 |=> left_q == ars_pkg::CNT_FULL)
    else $error("Zero count did not load 256 sectors.");
  chk_seek_first: assert property (
    rd_req_o |-> trk_of(ta_q) == trk_q)
    else $error("Sector read issued off the requested track.");
  chk_xreq_before: assert property (
    st_q == ars_pkg::ST_READ && (rd_ok_i || rd_fail_i)
    |=> xfer_req_o && st_q == ars_pkg::ST_XFER)
    else $error("Transfer request missing before data.");
  chk_done_zero: assert property (
    st_q == ars_pkg::ST_XFER && xfer_done_i && !err_q && left_q == 9'h001
    |=> cnt_reg_q == 8'h00 && $stable(ta_q) && !busy_q)
    else $error("Completion left wrong count or address.");
  chk_stop_fail: assert property (
    s_sector_bad |=> (!rd_req_o && !seek_req_o) [*2])
    else $error("Reading went on after a failed sector.");
  chk_fail_count: assert property (
    s_err_taken |=> cnt_reg_q == $past(left_lo) && $stable(ta_q))
    else $error("Failure report holds wrong count or address.");
  chk_feature_ign: assert property (
    wr_en && idx == ars_pkg::IDX_FEATURE |=> $stable(st_q) && $stable(er_q))
    else $error("Feature write disturbed the command.");
  chk_drive_sel: assert property (
    cmd_wr && !dv_ok && wb != ars_pkg::CMD_DIAG |=> !busy_q && $stable(er_q))
    else $error("Command ran for the other drive.");
endmodule : ars_read_cmd

/* File: test/ars_medium_model.sv */
// Behavioural medium and sector data mover for the sector read engine.
// Assumes one-cycle seek and read request pulses and a level transfer
// request that stays high until the mover answers.
`timescale 1ns/1ns
module ars_medium_model (
  input  wire logic clk_i,
  input  wire logic clr_i,
  input  wire logic slow_i,
  input  var int    fail_at_i,
  input  wire logic seek_req_i,
  input  wire logic rd_req_i,
  input  wire logic xfer_req_i,
  output logic      seek_done_o,
  output logic      rd_ok_o,
  output logic      rd_fail_o,
  output logic      xfer_done_o,
  output int        seeks_o,
  output int        reads_o,
  output int        xfers_o
);
  logic fail;

  initial begin
    seek_done_o = 1'b0;
    rd_ok_o = 1'b0;
    rd_fail_o = 1'b0;
    xfer_done_o = 1'b0;
  end

  // The head only settles on the track after a wait.
  always begin
    @(posedge clk_i);
    if (seek_req_i) begin
      repeat (slow_i ? 5 : 1) @(posedge clk_i);
      seek_done_o <= 1'b1;
      @(posedge clk_i);
      seek_done_o <= 1'b0;
    end
  end

  // A failure is only given at the sector the bench names.
  always begin
    @(posedge clk_i);
    if (rd_req_i) begin
      fail = (reads_o + 1 == fail_at_i);
      repeat (slow_i ? 5 : 1) @(posedge clk_i);
      rd_ok_o <= !fail;
      rd_fail_o <= fail;
      @(posedge clk_i);
      rd_ok_o <= 1'b0;
      rd_fail_o <= 1'b0;
    end
  end

  // Each raised transfer request is served exactly once.
  always begin
    @(posedge clk_i);
    if (xfer_req_i) begin
      repeat (slow_i ? 5 : 1) @(posedge clk_i);
      xfer_done_o <= 1'b1;
      @(posedge clk_i);
      xfer_done_o <= 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (clr_i) begin
      seeks_o <= 0;
      reads_o <= 0;
      xfers_o <= 0;
    end else begin
      seeks_o <= seeks_o + int'(seek_req_i);
      reads_o <= reads_o + int'(rd_req_i);
      xfers_o <= xfers_o + int'(xfer_done_o);
    end
  end
endmodule : ars_medium_model

/* File: test/ars_read_cmd_tb_top.sv */
// Self-checking bench of the sector read command block.
// Assumes the medium model file and the design package are compiled.
`timescale 1ns/1ns
module ars_read_cmd_tb_top;
  logic                  clk_i, rst_i, cyc, stb, we, slave, clr, slow;
  logic [10:0]           adr;
  logic [3:0]            sel;
  logic [31:0]           wdat, dat_o, q;
  logic                  ack_o, seek_req, seek_done, rd_req, rd_ok;
  logic                  rd_fail, lba_mode, xfer_req, xfer_done, last_mode;
  ars_pkg::ars_addr_type maddr, last_addr;
  logic [27:0]           lba, last_lba;
  int                    fail_at, seeks, reads, xfers;
  int                    err_total, compares, cycles;

  ars_read_cmd i_ars_read_cmd (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(dat_o), .ack_o(ack_o), .dev_is_slave_i(slave),
    .seek_req_o(seek_req), .seek_done_i(seek_done), .rd_req_o(rd_req),
    .rd_ok_i(rd_ok), .rd_fail_i(rd_fail), .media_addr_o(maddr),
    .media_lba_mode_o(lba_mode), .media_lba_o(lba),
    .xfer_req_o(xfer_req), .xfer_done_i(xfer_done));

  ars_medium_model i_ars_medium_model (.clk_i(clk_i), .clr_i(clr),
    .slow_i(slow), .fail_at_i(fail_at), .seek_req_i(seek_req),
    .rd_req_i(rd_req), .xfer_req_i(xfer_req), .seek_done_o(seek_done),
    .rd_ok_o(rd_ok), .rd_fail_o(rd_fail), .xfer_done_o(xfer_done),
    .seeks_o(seeks), .reads_o(reads), .xfers_o(xfers));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (rd_req) begin
      last_lba <= lba;
      last_addr <= maddr;
      last_mode <= lba_mode;
    end
  end

  // A hung handshake must still end in the closing report.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total++;
      stop_test;
    end
  end

  task automatic stop_test;
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Called just after a rising edge; holds the request until ack.
  task automatic wb(input logic w, input logic [8:0] idx,
                    input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    wdat <= {24'h000000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rdc(input logic [8:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk(q, {24'h000000, e});
  endtask : rdc

  task automatic idle;
    do wb(1'b0, ars_pkg::IDX_STATE, 8'h00); while ((q & 32'h88) != 0);
  endtask : idle

  task automatic cmd(input logic [7:0] dh, ch, cl, sn, sc, code);
    wb(1'b1, ars_pkg::IDX_FEATURE, 8'hA5);
    wb(1'b1, ars_pkg::IDX_COUNT, sc);
    wb(1'b1, ars_pkg::IDX_SECTOR, sn);
    wb(1'b1, ars_pkg::IDX_CYL_LO, cl);
    wb(1'b1, ars_pkg::IDX_CYL_HI, ch);
    wb(1'b1, ars_pkg::IDX_DRVHEAD, dh);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    wb(1'b1, ars_pkg::IDX_COMMAND, code);
  endtask : cmd

  task automatic ends(input logic [7:0] sc, sn, cl, ch, dh);
    rdc(ars_pkg::IDX_COUNT, sc);
    rdc(ars_pkg::IDX_SECTOR, sn);
    rdc(ars_pkg::IDX_CYL_LO, cl);
    rdc(ars_pkg::IDX_CYL_HI, ch);
    rdc(ars_pkg::IDX_DRVHEAD, dh);
  endtask : ends

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, slave, clr, slow} = 6'h00;
    adr = 11'h000;
    sel = 4'h0;
    wdat = 32'h0;
    fail_at = 0;
    err_total = 0;
    compares = 0;
    cycles = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    ends(8'h01, 8'h01, 8'h00, 8'h00, 8'hA0);
    rdc(ars_pkg::IDX_ERROR, 8'h01);
    rdc(ars_pkg::IDX_STATE, 8'h50);
    rdc(9'h000, 8'h00);
    // Logical mode across a sector boundary, option bit set.
    cmd(8'hE1, 8'h00, 8'h00, 8'h3E, 8'h03, 8'h21);
    idle;
    chk(q & 32'h89, 32'h0);
    chk(reads, 32'h3);
    chk(seeks, 32'h1);
    chk(xfers, 32'h3);
    chk(last_lba, 28'h1000040);
    chk(last_mode, 1'b1);
    ends(8'h00, 8'h40, 8'h00, 8'h00, 8'hE1);
    // Cylinder/head/sector mode wrapping onto the next head.
    cmd(8'hA5, 8'h00, 8'h00, 8'h3F, 8'h02, 8'h20);
    idle;
    chk(seeks, 32'h2);
    chk(last_mode, 1'b0);
    chk(last_addr, 32'hA6000001);
    ends(8'h00, 8'h01, 8'h00, 8'h00, 8'hA6);
    // The second sector fails; the rest must not be read.
    fail_at = 2;
    cmd(8'hA0, 8'h01, 8'h02, 8'h10, 8'h04, 8'h20);
    idle;
    fail_at = 0;
    chk(q & 32'h89, 32'h1);
    chk(reads, 32'h2);
    chk(xfers, 32'h2);
    chk(seeks, 32'h1);
    ends(8'h03, 8'h11, 8'h02, 8'h01, 8'hA0);
    rdc(ars_pkg::IDX_ERROR, 8'h40);
    // Strapped as slave; the master is addressed, then the slave with an unknown code.
    slave <= 1'b1;
    cmd(8'hA0, 8'h00, 8'h00, 8'h01, 8'h01, 8'h90);
    idle;
    rdc(ars_pkg::IDX_ERROR, 8'h01);
    cmd(8'hA0, 8'h00, 8'h00, 8'h01, 8'h01, 8'h20);
    idle;
    chk(reads, 32'h0);
    cmd(8'hB5, 8'h00, 8'h00, 8'h01, 8'h01, 8'hE7);
    idle;
    rdc(ars_pkg::IDX_ERROR, 8'h04);
    slave <= 1'b0;
    // A zero count reads 256 sectors; a write while busy is dropped.
    slow <= 1'b1;
    cmd(8'hE0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20);
    wb(1'b0, ars_pkg::IDX_STATE, 8'h00);
    chk(q & 32'h80, 32'h80);
    wb(1'b1, ars_pkg::IDX_CYL_HI, 8'h07);
    idle;
    chk(reads, 32'h100);
    ends(8'h00, 8'hFF, 8'h00, 8'h00, 8'hE0);
    stop_test;
  end
endmodule : ars_read_cmd_tb_top
